// ### logic/or_move_instruction_exec.sv
// Purpose: Decode and execute four single-cycle data-move instructions
// Assumes: File read data is combinational on the address in insn_i
// Notes:   One instruction per clock; other opcodes are ignored here
//
// Overview of operation
// RULE1: OR working with file, zero flag follows
// RULE2: Destination clear puts OR result in working
// RULE3: Destination set writes OR result to file
// RULE4: Move from file passes value, zero follows
// RULE5: Destination clear loads file value to working
// RULE6: Destination set rewrites same file, tests zero
// RULE7: Store working to file, flags untouched
// RULE8: Option load from working; all one cycle
`timescale 1ns/1ps

module or_move_instruction_exec
    import or_move_pkg::*;
(
    input  wire logic              clk_i,         // Core clock
    input  wire logic              reset_i,       // Sync reset, high
    input  wire logic              insn_valid_i,  // Instruction present
    input  wire logic [INSN_W-1:0] insn_i,        // Instruction word
    input  wire logic [DATA_W-1:0] file_rdata_i,  // Read data of file
    output file_wr_t               file_wr_o,     // File write request
    output zero_upd_t              zero_upd_o,    // Zero flag update
    output logic [DATA_W-1:0]      working_o,     // Working register
    output logic [DATA_W-1:0]      option_o,      // Option register
    output logic                   done_o         // Instruction retired
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    function automatic exec_op_t decode(input logic [INSN_W-1:0] w);
        exec_op_t                      op;
        logic [$bits(OP6_OR_FILE)-1:0] top6;
        logic [$bits(OP7_STORE_W)-1:0] top7;
        op   = OP_NONE;
        top6 = w[INSN_W-1 -: $bits(top6)];
        top7 = w[INSN_W-1 -: $bits(top7)];
        if (top6 == OP6_OR_FILE) begin
            op = OP_OR_WORKING_WITH_FILE;
        end else if (top6 == OP6_MOVE_FILE) begin
            op = OP_MOVE_FROM_FILE;
        end else if (top7 == OP7_STORE_W) begin
            op = OP_STORE_WORKING_TO_FILE;
        end else if (w == OP_OPTION_LOAD) begin
            op = OP_OPTION_LOAD_W;
        end
        return op;
    endfunction : decode

    exec_op_t          op;
    logic              dest_file;
    logic [ADDR_W-1:0] faddr;

    // Field extraction; file read address is the raw low bits
    assign op        = insn_valid_i ? decode(insn_i) : OP_NONE;
    assign dest_file = insn_i[DEST_BIT];
    assign faddr     = insn_i[ADDR_LSB +: ADDR_W];

    // ------------------------------------------------------------------
    // Execute state
    // ------------------------------------------------------------------
    file_wr_t          next_file_wr;
    zero_upd_t         next_zero_upd;
    logic [DATA_W-1:0] next_working;
    logic [DATA_W-1:0] next_option;
    logic              next_done;
    logic [DATA_W-1:0] result;

    // Compute result, destination and flag for the decoded op
    always_comb begin
        next_file_wr  = '0;
        next_zero_upd = '0;
        next_working  = working_o;
        next_option   = option_o;
        next_done     = 1'b0;
        result        = DATA_ZERO;
        unique case (op)
            OP_NONE: begin
            end
            OP_OR_WORKING_WITH_FILE: begin
                result              = working_o | file_rdata_i;   // [RULE1]
                next_zero_upd.en    = 1'b1;
                next_zero_upd.value = (result == DATA_ZERO);       // [RULE1]
                next_done           = 1'b1;                         // [RULE8]
                if (dest_file) begin
                    next_file_wr.en   = 1'b1;                       // [RULE3]
                    next_file_wr.addr = faddr;
                    next_file_wr.data = result;
                end else begin
                    next_working = result;                          // [RULE2]
                end
            end
            OP_MOVE_FROM_FILE: begin
                result              = file_rdata_i;                 // [RULE4]
                next_zero_upd.en    = 1'b1;
                next_zero_upd.value = (result == DATA_ZERO);       // [RULE4]
                next_done           = 1'b1;                         // [RULE8]
                if (dest_file) begin
                    next_file_wr.en   = 1'b1;                       // [RULE6]
                    next_file_wr.addr = faddr;
                    next_file_wr.data = result;
                end else begin
                    next_working = result;                          // [RULE5]
                end
            end
            OP_STORE_WORKING_TO_FILE: begin
                next_file_wr.en   = 1'b1;                           // [RULE7]
                next_file_wr.addr = faddr;
                next_file_wr.data = working_o;
                next_done         = 1'b1;                           // [RULE8]
            end
            OP_OPTION_LOAD_W: begin
                next_option = working_o;                            // [RULE8]
                next_done   = 1'b1;
            end
        endcase
    end

    // Register all outputs
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            file_wr_o  <= '0;
            zero_upd_o <= '0;
            working_o  <= W_RESET;
            option_o   <= OPTION_RESET;
            done_o     <= 1'b0;
        end else begin
            file_wr_o  <= next_file_wr;
            zero_upd_o <= next_zero_upd;
            working_o  <= next_working;
            option_o   <= next_option;
            done_o     <= next_done;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // OR reports zero from the OR of W and f
    a_or_zero_flag: assert property ( // [RULE1]
        @(posedge clk_i) disable iff (reset_i)
        op == OP_OR_WORKING_WITH_FILE |=> zero_upd_o.en &&
        zero_upd_o.value ==
            (($past(working_o) | $past(file_rdata_i)) == DATA_ZERO))
        else $error("OR zero flag wrong");

    // OR with destination clear lands in W only
    a_or_to_working: assert property ( // [RULE2]
        @(posedge clk_i) disable iff (reset_i)
        op == OP_OR_WORKING_WITH_FILE && !dest_file |=> !file_wr_o.en &&
        working_o == ($past(working_o) | $past(file_rdata_i)))
        else $error("OR to working wrong");

    // OR with destination set writes back to f, W kept
    a_or_to_file: assert property ( // [RULE3]
        @(posedge clk_i) disable iff (reset_i)
        op == OP_OR_WORKING_WITH_FILE && dest_file |=> file_wr_o.en &&
        file_wr_o.addr == $past(faddr) && working_o == $past(working_o) &&
        file_wr_o.data == ($past(working_o) | $past(file_rdata_i)))
        else $error("OR to file wrong");

    // Move reports zero from the file value
    a_move_zero_flag: assert property ( // [RULE4]
        @(posedge clk_i) disable iff (reset_i)
        op == OP_MOVE_FROM_FILE |=> zero_upd_o.en &&
        zero_upd_o.value == ($past(file_rdata_i) == DATA_ZERO))
        else $error("Move zero flag wrong");

    // Move with destination clear loads W, no write
    a_move_to_working: assert property ( // [RULE5]
        @(posedge clk_i) disable iff (reset_i)
        op == OP_MOVE_FROM_FILE && !dest_file |=>
        working_o == $past(file_rdata_i) && !file_wr_o.en)
        else $error("Move to working wrong");

    // Move with destination set rewrites the same f, W kept
    a_move_to_file: assert property ( // [RULE6]
        @(posedge clk_i) disable iff (reset_i)
        op == OP_MOVE_FROM_FILE && dest_file |=> file_wr_o.en &&
        file_wr_o.addr == $past(faddr) &&
        file_wr_o.data == $past(file_rdata_i) && working_o == $past(working_o))
        else $error("Move to file wrong");

    // Store copies W to f with no flag update
    a_store_working: assert property ( // [RULE7]
        @(posedge clk_i) disable iff (reset_i)
        op == OP_STORE_WORKING_TO_FILE |=> file_wr_o.en &&
        file_wr_o.data == $past(working_o) && !zero_upd_o.en &&
        file_wr_o.addr == $past(faddr))
        else $error("Store working wrong");

    // Store leaves W and option alone
    a_store_keeps_regs: assert property ( // [RULE7]
        @(posedge clk_i) disable iff (reset_i)
        op == OP_STORE_WORKING_TO_FILE |=> working_o == $past(working_o) &&
        option_o == $past(option_o))
        else $error("Store changed a register");

    // Option load copies W, keeps W, no write, no flag
    a_option_load: assert property ( // [RULE8]
        @(posedge clk_i) disable iff (reset_i)
        op == OP_OPTION_LOAD_W |=> option_o == $past(working_o) &&
        working_o == $past(working_o) &&
        done_o && !zero_upd_o.en && !file_wr_o.en)
        else $error("Option load wrong");

    // Each of the four retires one edge after it is taken
    a_four_done: assert property ( // [RULE8]
        @(posedge clk_i) disable iff (reset_i)
        op != OP_NONE |=> done_o)
        else $error("Instruction not retired");

    // Option changes only on the option load
    a_opt_only_load: assert property ( // [RULE8]
        @(posedge clk_i) disable iff (reset_i)
        op != OP_OPTION_LOAD_W |=> option_o == $past(option_o))
        else $error("Option changed unasked");

    // Idle slots and other words leave no trace
    a_refused_quiet: assert property ( // [RULE8]
        @(posedge clk_i) disable iff (reset_i)
        op == OP_NONE |=> !done_o && !file_wr_o.en && !zero_upd_o.en &&
        working_o == $past(working_o))
        else $error("Refused word had an effect");

    // Reset puts every output at its idle value one edge later
    a_reset_values: assert property (@(posedge clk_i)
        reset_i |=> working_o == W_RESET && option_o == OPTION_RESET &&
        !done_o && !file_wr_o.en && !zero_upd_o.en)
        else $error("Reset values wrong");

endmodule : or_move_instruction_exec

// ### logic/or_move_pkg.sv
// Purpose: Constants and carrier types for the OR/move execute block
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses
// Notes:   Opcode patterns are matched on the upper bits of the word, option load on the whole word
package or_move_pkg;

    // ------------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------------
    localparam int INSN_W     = 14;
    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 7;
    localparam int DEST_BIT   = 7;
    localparam int ADDR_LSB   = 0;

    // ------------------------------------------------------------------
    // Opcode patterns
    // ------------------------------------------------------------------
    localparam logic [5:0]  OP6_OR_FILE    = 6'h04; // 00 0100
    localparam logic [5:0]  OP6_MOVE_FILE  = 6'h08; // 00 1000
    localparam logic [6:0]  OP7_STORE_W    = 7'h01; // 00 0000 1
    localparam logic [13:0] OP_OPTION_LOAD = 14'h0062;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] W_RESET      = 8'h00;
    localparam logic [7:0] OPTION_RESET = 8'hFF;
    localparam logic [7:0] DATA_ZERO    = 8'h00;

    // Decoded operation
    typedef enum logic [2:0] {
        OP_NONE,
        OP_OR_WORKING_WITH_FILE,
        OP_MOVE_FROM_FILE,
        OP_STORE_WORKING_TO_FILE,
        OP_OPTION_LOAD_W
    } exec_op_t;

    // File register write request
    typedef struct packed {
        logic             en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } file_wr_t;

    // Zero flag update request
    typedef struct packed {
        logic en;
        logic value;
    } zero_upd_t;

endpackage : or_move_pkg

// ### tb/file_reg_model.sv
// Purpose: Register file beside the execute block
// Assumes: Read is combinational, write lands on the clock edge
// Notes:   Address i powers up holding value i
`timescale 1ns/1ps
module file_reg_model
    import or_move_pkg::*;
(
    input  wire logic              clk_i,   // Core clock
    input  wire logic [ADDR_W-1:0] raddr_i, // Read address
    input  wire file_wr_t          wr_i,    // Write request
    output logic [DATA_W-1:0]      rdata_o  // Read data
);
    logic [DATA_W-1:0] mem [128];
    // Power-up contents
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = DATA_W'(i);
        end
    end
    // Read path and write port; no bypass, like a real array
    assign rdata_o = mem[raddr_i];
    always @(posedge clk_i) begin
        if (wr_i.en === 1'b1) begin
            mem[wr_i.addr] <= wr_i.data;
        end
    end
endmodule : file_reg_model

// ### tb/or_move_instruction_exec_tb.sv
// Purpose: Self-checking bench for the OR/move execute block
// Assumes: Expected file data is what the model drove that cycle
// Notes:   Random mix of the four patterns, other words, idle slots
`timescale 1ns/1ps
module or_move_instruction_exec_tb;
    import or_move_pkg::*;
    typedef struct packed {
        logic              done;
        file_wr_t          wr;
        zero_upd_t         zu;
        logic [DATA_W-1:0] w;
        logic [DATA_W-1:0] opt;
    } exp_t;
    logic clk_i, reset_i, insn_valid_i, done_o;
    logic [INSN_W-1:0] insn_i;
    logic [DATA_W-1:0] file_rdata_i, working_o, option_o, w_m, opt_m;
    file_wr_t  file_wr_o;
    zero_upd_t zero_upd_o;
    int err_count, n_checks;
    logic [13:0] corner [9] = '{14'h0400, 14'h0880, 14'h0800, 14'h0493,
        14'h0813, 14'h0062, 14'h0085, 14'h0008, 14'h0485};
    or_move_instruction_exec or_move_instruction_exec_inst (.clk_i(clk_i),
        .reset_i(reset_i), .insn_valid_i(insn_valid_i), .insn_i(insn_i),
        .file_rdata_i(file_rdata_i), .file_wr_o(file_wr_o),
        .zero_upd_o(zero_upd_o), .working_o(working_o),
        .option_o(option_o), .done_o(done_o));
    file_reg_model file_reg_model_inst (.clk_i(clk_i),
        .raddr_i(insn_i[6:0]), .wr_i(file_wr_o), .rdata_o(file_rdata_i));
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Expected outputs one edge after an instruction
    function automatic exp_t predict(logic v, logic [13:0] i,
        logic [7:0] f, logic [7:0] w, logic [7:0] o);
        exp_t e;
        logic [7:0] r;
        e = '0;
        e.w = w;
        e.opt = o;
        r = (i[13:8] == OP6_OR_FILE) ? (w | f) : f;
        if (v && (i[13:8] == OP6_OR_FILE || i[13:8] == OP6_MOVE_FILE)) begin
            e.done = 1'b1;
            e.zu = {1'b1, r == 8'h00};
            if (i[7]) e.wr = {1'b1, i[6:0], r};
            else e.w = r;
        end else if (v && i[13:7] == OP7_STORE_W) begin
            e.done = 1'b1;
            e.wr = {1'b1, i[6:0], w};
        end else if (v && i == OP_OPTION_LOAD) begin
            e.done = 1'b1;
            e.opt = w;
        end
        return e;
    endfunction : predict
    function automatic logic [13:0] pick(int unsigned k, logic [7:0] a);
        case (k % 5)
            0: return {OP6_OR_FILE, a};
            1: return {OP6_MOVE_FILE, a};
            2: return {OP7_STORE_W, a[6:0]};
            3: return OP_OPTION_LOAD;
            default: return 14'($urandom);
        endcase
    endfunction : pick
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    // One instruction slot, checked after the taking edge
    task automatic run(input logic v, input logic [13:0] i);
        exp_t e;
        @(negedge clk_i);
        insn_valid_i = v;
        insn_i = i;
        #1;
        e = predict(v, i, file_rdata_i, w_m, opt_m);
        @(posedge clk_i);
        #1;
        w_m = e.w;
        opt_m = e.opt;
        chk(done_o === e.done, "done");
        chk(file_wr_o.en === e.wr.en, "wr en");
        if (e.wr.en) chk(file_wr_o === e.wr, "wr");
        chk(zero_upd_o.en === e.zu.en, "z en");
        if (e.zu.en) chk(zero_upd_o === e.zu, "z");
        chk(working_o === e.w, "W");
        chk(option_o === e.opt, "opt");
    endtask : run
    // Reset with a live instruction that must be ignored
    task automatic do_reset();
        @(negedge clk_i);
        reset_i = 1'b1;
        insn_valid_i = 1'b1;
        insn_i = OP_OPTION_LOAD;
        repeat (5) @(negedge clk_i);
        chk(working_o === W_RESET && option_o === OPTION_RESET, "rst");
        chk(done_o === 1'b0 && file_wr_o.en === 1'b0, "rst pulse");
        reset_i = 1'b0;
        insn_valid_i = 1'b0;
        w_m = W_RESET;
        opt_m = OPTION_RESET;
    endtask : do_reset
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    // Watchdog
    initial begin
        #20us;
        err_count++;
        stop_test();
    end
    // Main sequence
    initial begin
        reset_i = 1'b1;
        insn_valid_i = 1'b0;
        insn_i = '0;
        err_count = 0;
        n_checks = 0;
        void'($urandom(32'hE82A));
        do_reset();
        foreach (corner[k]) run(1'b1, corner[k]);
        $display("Test corner done");
        repeat (400) run(1'($urandom % 8 != 0), pick($urandom, 8'($urandom)));
        $display("Test random done");
        do_reset();
        run(1'b1, OP_OPTION_LOAD);
        $display("Test reset done");
        stop_test();
    end
endmodule : or_move_instruction_exec_tb
